// ### rtl/rcf_pkg.sv
package rcf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_FLAGS      = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, shared by flags, interrupt status and mask
  localparam int BIT_STACK_OVERFLOW  = 7;
  localparam int BIT_STACK_UNDERFLOW = 6;
  localparam int BIT_UNUSED          = 5;
  localparam int BIT_WATCHDOG_RESET  = 4;
  localparam int BIT_PIN_RESET       = 3;
  localparam int BIT_SOFTWARE_RESET  = 2;
  localparam int BIT_POWER_ON        = 1;
  localparam int BIT_BROWN_OUT       = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and masks
  localparam logic [7:0] FLAGS_POR_RESET      = 8'h1C;
  localparam logic [7:0] FLAGS_WRITABLE       = 8'hDF;
  localparam logic [7:0] IRQ_STATUS_RESET     = 8'h02;
  localparam logic [7:0] IRQ_MASK_RESET       = 8'h00;
  localparam logic [7:0] IRQ_IMPLEMENTED      = 8'hDF;

endpackage

// ### rtl/rcf_wb_slave.sv
`timescale 1ns/1ns
module rcf_wb_slave (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [7:0]  flags_in,
  input  wire logic [7:0]  irq_status_in,
  input  wire logic [7:0]  irq_mask_in,
  output logic             wb_ack_out,
  output logic      [31:0] wb_dat_out,
  output logic             wr_flags_out,
  output logic             wr_status_out,
  output logic             wr_mask_out
);

  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        req;
  logic        wr_lane;

  ////////////////////////////////////////////////////////////////////////////
  // One wait state; write commits at the ack edge, when the master samples
  assign req     = wb_cyc_in & wb_stb_in;
  assign wr_lane = req & ack_reg & wb_we_in & wb_sel_in[0];

  always_comb begin
    ack_next = req & ~ack_reg;
    dat_next = dat_reg;
    if (req && !ack_reg) begin
      case (wb_adr_in)
        rcf_pkg::ADDR_FLAGS:      dat_next = {24'h000000, flags_in};
        rcf_pkg::ADDR_IRQ_STATUS: dat_next = {24'h000000, irq_status_in};
        rcf_pkg::ADDR_IRQ_MASK:   dat_next = {24'h000000, irq_mask_in};
        default:                  dat_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_out    = ack_reg;
  assign wb_dat_out    = dat_reg;
  assign wr_flags_out  = wr_lane && (wb_adr_in == rcf_pkg::ADDR_FLAGS);
  assign wr_status_out = wr_lane && (wb_adr_in == rcf_pkg::ADDR_IRQ_STATUS);
  assign wr_mask_out   = wr_lane && (wb_adr_in == rcf_pkg::ADDR_IRQ_MASK);

endmodule

// ### rtl/rcf_irq.sv
`timescale 1ns/1ns
module rcf_irq (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] event_in,
  input  wire logic       wr_status_in,
  input  wire logic       wr_mask_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] status_out,
  output logic      [7:0] mask_out,
  output logic            irq_out
);

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;

  ////////////////////////////////////////////////////////////////////////////
  // Write one to clear; a fresh event beats the clear
  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    if (wr_status_in) begin
      status_next = status_reg & ~wdata_in;
    end
    if (wr_mask_in) begin
      mask_next = wdata_in & rcf_pkg::IRQ_IMPLEMENTED;
    end
    status_next = (status_next | event_in) & rcf_pkg::IRQ_IMPLEMENTED;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_reg <= rcf_pkg::IRQ_STATUS_RESET;
      mask_reg   <= rcf_pkg::IRQ_MASK_RESET;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

  assign status_out = status_reg;
  assign mask_out   = mask_reg;
  assign irq_out    = |(status_reg & mask_reg);

endmodule

// ### rtl/rcf_reset_cause_flags.sv
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
module rcf_reset_cause_flags (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        brown_out_event_in,
  input  wire logic        watchdog_reset_event_in,
  input  wire logic        pin_reset_event_in,
  input  wire logic        software_reset_event_in,
  input  wire logic        stack_overflow_event_in,
  input  wire logic        stack_underflow_event_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic      [7:0]  reset_cause_flags_out,
  output logic             irq_out
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] wdata;
  logic [7:0] irq_events;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic       wr_flags;
  logic       wr_status;
  logic       wr_mask;

  assign wdata = wb_dat_in[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  rcf_wb_slave u_bus (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .wb_cyc_in     (wb_cyc_in),
    .wb_stb_in     (wb_stb_in),
    .wb_we_in      (wb_we_in),
    .wb_adr_in     (wb_adr_in),
    .wb_sel_in     (wb_sel_in),
    .flags_in      (flags_reg),
    .irq_status_in (irq_status),
    .irq_mask_in   (irq_mask),
    .wb_ack_out    (wb_ack_out),
    .wb_dat_out    (wb_dat_out),
    .wr_flags_out  (wr_flags),
    .wr_status_out (wr_status),
    .wr_mask_out   (wr_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag update
  // Order matters: software first, brown-out defaults next, single causes
  // last, so a hardware event in the same cycle is never lost.
  always_comb begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = wdata & rcf_pkg::FLAGS_WRITABLE;
    end
    if (brown_out_event_in) begin
      flags_next[rcf_pkg::BIT_STACK_OVERFLOW]  = 1'b0;
      flags_next[rcf_pkg::BIT_STACK_UNDERFLOW] = 1'b0;
      flags_next[rcf_pkg::BIT_WATCHDOG_RESET]  = 1'b1;
      flags_next[rcf_pkg::BIT_PIN_RESET]       = 1'b1;
      flags_next[rcf_pkg::BIT_SOFTWARE_RESET]  = 1'b1;
      flags_next[rcf_pkg::BIT_BROWN_OUT]       = 1'b0;
    end
    if (stack_overflow_event_in) begin
      flags_next[rcf_pkg::BIT_STACK_OVERFLOW] = 1'b1;
    end
    if (stack_underflow_event_in) begin
      flags_next[rcf_pkg::BIT_STACK_UNDERFLOW] = 1'b1;
    end
    if (watchdog_reset_event_in) begin
      flags_next[rcf_pkg::BIT_WATCHDOG_RESET] = 1'b0;
    end
    if (pin_reset_event_in) begin
      flags_next[rcf_pkg::BIT_PIN_RESET] = 1'b0;
    end
    if (software_reset_event_in) begin
      flags_next[rcf_pkg::BIT_SOFTWARE_RESET] = 1'b0;
    end
    flags_next[rcf_pkg::BIT_UNUSED] = 1'b0;
  end

  // The async reset is the power-on reset; flags survive all other causes but brown-out, which reloads the defaults of bits 7, 6 and 4 to 2
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_reg <= rcf_pkg::FLAGS_POR_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign reset_cause_flags_out = flags_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: one status bit per cause, same layout as the flags
  always_comb begin
    irq_events                                = 8'h00;
    irq_events[rcf_pkg::BIT_STACK_OVERFLOW]   = stack_overflow_event_in;
    irq_events[rcf_pkg::BIT_STACK_UNDERFLOW]  = stack_underflow_event_in;
    irq_events[rcf_pkg::BIT_WATCHDOG_RESET]   = watchdog_reset_event_in;
    irq_events[rcf_pkg::BIT_PIN_RESET]        = pin_reset_event_in;
    irq_events[rcf_pkg::BIT_SOFTWARE_RESET]   = software_reset_event_in;
    irq_events[rcf_pkg::BIT_BROWN_OUT]        = brown_out_event_in;
  end

  rcf_irq u_irq (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .event_in     (irq_events),
    .wr_status_in (wr_status),
    .wr_mask_in   (wr_mask),
    .wdata_in     (wdata),
    .status_out   (irq_status),
    .mask_out     (irq_mask),
    .irq_out      (irq_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  logic any_event;
  assign any_event = brown_out_event_in | watchdog_reset_event_in | pin_reset_event_in |
                     software_reset_event_in | stack_overflow_event_in |
                     stack_underflow_event_in;

  AST_OVF_SET: assert property (
    stack_overflow_event_in |=> reset_cause_flags_out[7] && irq_status[7])
    else $error("Overflow flag not set");

  AST_UNF_SET: assert property (
    stack_underflow_event_in |=> reset_cause_flags_out[6])
    else $error("Underflow flag not set");

  AST_STACK_CLEAR: assert property (
    wr_flags && !wdata[7] && !stack_overflow_event_in
    |=> !reset_cause_flags_out[7])
    else $error("Overflow flag not cleared by software");

  AST_WDT_CLEAR: assert property (
    watchdog_reset_event_in |=> !reset_cause_flags_out[4])
    else $error("Watchdog flag not cleared");

  AST_PIN_CLEAR: assert property (
    pin_reset_event_in |=> !reset_cause_flags_out[3])
    else $error("Pin reset flag not cleared");

  AST_SW_CLEAR: assert property (
    software_reset_event_in |=> !reset_cause_flags_out[2])
    else $error("Software reset flag not cleared");

  AST_POR_RISE: assert property (
    $rose(reset_cause_flags_out[1]) |-> $past(wr_flags) && $past(wdata[1]))
    else $error("Power-on flag rose without a write");

  AST_BOR_DEFAULTS: assert property (
    brown_out_event_in && !watchdog_reset_event_in && !pin_reset_event_in &&
    !software_reset_event_in && !stack_overflow_event_in && !stack_underflow_event_in
    |=> reset_cause_flags_out[7:6] == 2'b00 && reset_cause_flags_out[4:2] == 3'b111 &&
        !reset_cause_flags_out[0])
    else $error("Brown-out defaults wrong");

  AST_REARM: assert property (
    wr_flags && wdata[4] && !watchdog_reset_event_in |=> reset_cause_flags_out[4])
    else $error("Watchdog flag not rearmed");

  // Checked every cycle; gating it on ack would mask the flag bit itself
  AST_BIT5_ZERO: assert property (
    !reset_cause_flags_out[5] && !irq_status[5] && !(wb_ack_out && wb_dat_out[5]))
    else $error("Unused bit reads nonzero");

  AST_HOLD: assert property (
    !any_event && !wr_flags |=> $stable(reset_cause_flags_out))
    else $error("Flags changed with no cause");

  AST_ACK_ONE: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("Ack held two cycles");

  COV_OVF_IRQ: cover property (stack_overflow_event_in ##1 irq_out);
  COV_REARM: cover property (watchdog_reset_event_in ##[1:20] (wr_flags && wdata[4]));
  COV_BOR: cover property (brown_out_event_in ##1 !reset_cause_flags_out[0]);

endmodule

// ### tb/rcf_reset_cause_flags_tb_top.sv
`timescale 1ns/1ns
module rcf_reset_cause_flags_tb_top;
  logic        clk_in;
  logic        reset_n_in;
  logic [7:0]  ev;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic [7:0]  flags_out;
  logic        irq_out;
  int          mismatches;
  int          checked;

  rcf_reset_cause_flags dut (
    .clk_in                   (clk_in),
    .reset_n_in               (reset_n_in),
    .brown_out_event_in       (ev[0]),
    .watchdog_reset_event_in  (ev[4]),
    .pin_reset_event_in       (ev[3]),
    .software_reset_event_in  (ev[2]),
    .stack_overflow_event_in  (ev[7]),
    .stack_underflow_event_in (ev[6]),
    .wb_cyc_in                (cyc),
    .wb_stb_in                (stb),
    .wb_we_in                 (we),
    .wb_adr_in                (adr),
    .wb_sel_in                (sel),
    .wb_dat_in                (wdat),
    .wb_dat_out               (wb_dat_out),
    .wb_ack_out               (wb_ack_out),
    .reset_cause_flags_out    (flags_out),
    .irq_out                  (irq_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  // Held until ack is sampled; waits are bounded so a dead slave cannot hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    rdat = wb_dat_out;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(name, {24'h0, exp}, rdat);
  endtask

  task automatic pulse(input int b);
    @(posedge clk_in);
    ev[b] <= 1'b1;
    @(posedge clk_in);
    ev <= 8'h00;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_por();
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk("flags_out", 32'h1C, {24'h0, flags_out});
    rd_chk("flags", rcf_pkg::ADDR_FLAGS, 8'h1C);
    rd_chk("irq_status", rcf_pkg::ADDR_IRQ_STATUS, 8'h02);
    rd_chk("irq_mask", rcf_pkg::ADDR_IRQ_MASK, 8'h00);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    $display("test_por done");
  endtask

  task automatic test_regs();
    wb(1'b1, rcf_pkg::ADDR_FLAGS, 32'hFF, 4'hF);
    rd_chk("flags", rcf_pkg::ADDR_FLAGS, 8'hDF);
    wb(1'b1, rcf_pkg::ADDR_FLAGS, 32'h00, 4'hE);
    rd_chk("flags", rcf_pkg::ADDR_FLAGS, 8'hDF);
    wb(1'b1, rcf_pkg::ADDR_FLAGS, 32'h00, 4'hF);
    rd_chk("flags", rcf_pkg::ADDR_FLAGS, 8'h00);
    rd_chk("unmapped", 8'h0C, 8'h00);
    $display("test_regs done");
  endtask

  // Cumulative: each event must touch its own bit only, except brown-out, which also loads the defaults of bits 7, 6 and 4 to 2
  task automatic test_events();
    int          bits [6] = '{7, 6, 4, 3, 2, 0};
    logic [7:0]  exp  [6] = '{8'h9F, 8'hDF, 8'hCF, 8'hC7, 8'hC3, 8'h1E};
    wb(1'b1, rcf_pkg::ADDR_FLAGS, 32'h1F, 4'hF);
    rd_chk("flags", rcf_pkg::ADDR_FLAGS, 8'h1F);
    for (int i = 0; i < 6; i++) begin
      pulse(bits[i]);
      chk("flags_out", {24'h0, exp[i]}, {24'h0, flags_out});
    end
    rd_chk("flags", rcf_pkg::ADDR_FLAGS, 8'h1E);
    $display("test_events done");
  endtask

  task automatic test_irq();
    rd_chk("irq_status", rcf_pkg::ADDR_IRQ_STATUS, 8'hDF);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    wb(1'b1, rcf_pkg::ADDR_IRQ_MASK, 32'h10, 4'hF);
    #1;
    chk("irq_out", 32'h1, {31'h0, irq_out});
    wb(1'b1, rcf_pkg::ADDR_IRQ_STATUS, 32'h10, 4'hF);
    @(posedge clk_in);
    #1;
    chk("irq_out", 32'h0, {31'h0, irq_out});
    rd_chk("irq_status", rcf_pkg::ADDR_IRQ_STATUS, 8'hCF);
    pulse(4);
    chk("irq_out", 32'h1, {31'h0, irq_out});
    wb(1'b1, rcf_pkg::ADDR_IRQ_STATUS, 32'hFF, 4'hF);
    rd_chk("irq_status", rcf_pkg::ADDR_IRQ_STATUS, 8'h00);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    $display("test_irq done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    checked    = 0;
    reset_n_in = 1'b0;
    ev         = 8'h00;
    cyc        = 1'b0;
    stb        = 1'b0;
    we         = 1'b0;
    adr        = 8'h00;
    sel        = 4'h0;
    wdat       = 32'h0;
    test_por();
    test_regs();
    test_events();
    test_irq();
    test_por();
    test_done();
  end
endmodule
